// ===== logic/acp_pkg.sv
// Constants and types shared by the converter control byte port
package acp_pkg;

  // ****************************************
  // Control byte layout
  // ****************************************
  localparam int unsigned CTRL_W        = 8;
  localparam int unsigned RES_W         = 10;
  localparam int unsigned POS_POWER_HI  = 7;
  localparam int unsigned POS_POWER_LO  = 6;
  localparam int unsigned POS_SAMPLE    = 5;
  localparam int unsigned POS_INPUT_REF = 4;
  localparam int unsigned POS_POLARITY  = 3;
  localparam int unsigned POS_CHAN_HI   = 2;
  localparam int unsigned POS_CHAN_LO   = 0;
  localparam int unsigned CHAN_W        = 3;
  localparam int unsigned LOW_BYTE_W    = 8;
  localparam int unsigned HIGH_BITS_W   = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CTRL_W-1:0] CTRL_RST   = 8'h00;
  localparam logic [1:0]        POWER_RST  = 2'h3;
  localparam logic              CLK_INT_RST = 1'b0;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned MCLK_MHZ       = 40;
  localparam int unsigned CONV_TIME_NS   = 3600;
  localparam int unsigned ACQ_TIME_NS    = 1000;
  localparam int unsigned CONV_CYC       = CONV_TIME_NS * MCLK_MHZ / 1000;
  localparam int unsigned ACQ_CYC        = ACQ_TIME_NS * MCLK_MHZ / 1000;
  localparam int unsigned CONV_EDGES     = 13;
  localparam int unsigned ACQ_EDGES      = 3;
  localparam int unsigned CNT_W          = 8;

  typedef enum logic [1:0] {
    ACP_IDLE,
    ACP_ACQ_INT,
    ACP_ACQ_EXT,
    ACP_CONV
  } acp_state_e;

endpackage : acp_pkg

// ===== logic/acp_port.sv
// Control byte decoder and 8+2 parallel host port of a 10-bit converter
`timescale 1ns/1ps

module acp_port
  import acp_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = acp_pkg::CONV_CYC,
  parameter int unsigned ACQ_CYCLES  = acp_pkg::ACQ_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        chip_select_n,
  input  wire logic                        store_strobe_n,
  input  wire logic                        fetch_strobe_n,
  input  wire logic                        upper_byte_select,
  input  wire logic                        conv_clk,
  input  wire logic [acp_pkg::CTRL_W-1:0]  data_in,
  input  wire logic [acp_pkg::RES_W-1:0]   sample_code,
  output logic      [acp_pkg::CTRL_W-1:0]  data_out,
  output logic                             data_oe_n,
  output logic                             done_flag_n,
  output logic      [1:0]                  power_mode,
  output logic                             clock_internal,
  output logic                             sample_window_sel,
  output logic                             input_ref_sel,
  output logic                             polarity_sel,
  output logic      [acp_pkg::CHAN_W-1:0]  chan_sel,
  output logic                             tracking,
  output logic                             converting
);
  import acp_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    acp_state_e          state;
    logic                store_prev_n;
    logic                fetch_prev_n;
    logic                conv_clk_prev;
    logic [CTRL_W-1:0]   latch;
    logic [CTRL_W-1:0]   ctrl;
    logic                clk_int;
    logic [CNT_W-1:0]    cnt;
    logic [RES_W-1:0]    result;
    logic                done_n;
    logic [CTRL_W-1:0]   dout;
    logic                doe_n;
    logic                trk;
    logic                cnv;
  } acp_regs_s;

  localparam acp_regs_s REGS_RST = '{
    state:         ACP_IDLE,
    store_prev_n:  1'b1,
    fetch_prev_n:  1'b1,
    conv_clk_prev: 1'b0,
    latch:         CTRL_RST,
    ctrl:          CTRL_RST,
    clk_int:       CLK_INT_RST,
    cnt:           '0,
    result:        '0,
    done_n:        1'b1,
    dout:          '0,
    doe_n:         1'b1,
    trk:           1'b0,
    cnv:           1'b0
  };

  acp_regs_s regs_ff;
  acp_regs_s nxt_regs;

  logic              commit;
  logic              read_start;
  logic              tick;
  logic              finish;
  logic              normal_op;
  logic [CNT_W-1:0]  acq_last;
  logic [CNT_W-1:0]  conv_last;

  always_comb begin
    // Strobes only count while selected
    commit     = !chip_select_n && store_strobe_n && !regs_ff.store_prev_n;
    read_start = !chip_select_n && !fetch_strobe_n && regs_ff.fetch_prev_n;
    normal_op  = regs_ff.latch[POS_POWER_HI];
    // Pin level never reaches timing in internal mode
    tick = regs_ff.clk_int ? 1'b1
         : (!chip_select_n && conv_clk && !regs_ff.conv_clk_prev);
    acq_last  = regs_ff.clk_int ? CNT_W'(ACQ_CYCLES - 1) : CNT_W'(ACQ_EDGES - 1);
    conv_last = regs_ff.clk_int ? CNT_W'(CONV_CYCLES - 1) : CNT_W'(CONV_EDGES - 1);
    finish = regs_ff.state == ACP_CONV && tick && regs_ff.cnt == conv_last;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.store_prev_n  = chip_select_n | store_strobe_n;
    nxt_regs.fetch_prev_n  = chip_select_n | fetch_strobe_n;
    nxt_regs.conv_clk_prev = conv_clk;
    // Byte is held while the write strobe is low, committed on its rise
    if (!chip_select_n && !store_strobe_n) begin
      nxt_regs.latch = data_in;
    end
    if (tick) begin
      nxt_regs.cnt = regs_ff.cnt + CNT_W'(1);
    end
    case (regs_ff.state)
      ACP_ACQ_INT: begin
        if (tick && regs_ff.cnt == acq_last) begin
          nxt_regs.state = ACP_CONV;
          nxt_regs.cnt   = '0;
        end
      end
      ACP_CONV: begin
        if (finish) begin
          nxt_regs.state = ACP_IDLE;
          nxt_regs.done_n = 1'b0;
          // Raw code is offset binary; bipolar flips the sign bit
          nxt_regs.result = regs_ff.ctrl[POS_POLARITY] ? sample_code
                          : {~sample_code[RES_W-1], sample_code[RES_W-2:0]};
        end
      end
      default: begin
      end
    endcase
    if (read_start && !finish) begin
      nxt_regs.done_n = 1'b1;
    end
    if (commit) begin
      nxt_regs.ctrl   = regs_ff.latch;
      nxt_regs.cnt    = '0;
      nxt_regs.done_n = 1'b1;
      if (normal_op) begin
        nxt_regs.clk_int = !regs_ff.latch[POS_POWER_LO];
        if (regs_ff.latch[POS_SAMPLE]) begin
          nxt_regs.state = ACP_ACQ_EXT;
        end else if (regs_ff.state == ACP_ACQ_EXT) begin
          nxt_regs.state = ACP_CONV;
        end else begin
          nxt_regs.state = ACP_ACQ_INT;
        end
      end else begin
        // Power-down aborts work; clock mode left alone
        nxt_regs.state = ACP_IDLE;
      end
    end
    // Output stage: registered, one cycle behind the pins
    nxt_regs.doe_n = chip_select_n | fetch_strobe_n;
    if (upper_byte_select) begin
      nxt_regs.dout = {{(CTRL_W-HIGH_BITS_W){!regs_ff.ctrl[POS_POLARITY]
                        & regs_ff.result[RES_W-1]}},
                       regs_ff.result[RES_W-1:LOW_BYTE_W]};
    end else begin
      nxt_regs.dout = regs_ff.result[LOW_BYTE_W-1:0];
    end
    // Status registered so the pins never see decode glitches
    nxt_regs.trk = nxt_regs.state == ACP_ACQ_INT || nxt_regs.state == ACP_ACQ_EXT;
    nxt_regs.cnv = nxt_regs.state == ACP_CONV;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regs_ff <= REGS_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_comb begin
    data_out          = regs_ff.dout;
    data_oe_n         = regs_ff.doe_n;
    done_flag_n       = regs_ff.done_n;
    power_mode        = regs_ff.ctrl[POS_POWER_HI:POS_POWER_LO];
    clock_internal    = regs_ff.clk_int;
    sample_window_sel = regs_ff.ctrl[POS_SAMPLE];
    input_ref_sel     = regs_ff.ctrl[POS_INPUT_REF];
    polarity_sel      = regs_ff.ctrl[POS_POLARITY];
    chan_sel          = regs_ff.ctrl[POS_CHAN_HI:POS_CHAN_LO];
    tracking          = regs_ff.trk;
    converting        = regs_ff.cnv;
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_clock_select;
    @(posedge mclk) disable iff (!resetn)
      commit && normal_op |=> clock_internal == !$past(regs_ff.latch[POS_POWER_LO]);
  endproperty
  a_clock_select: assert property (p_clock_select)
    else $error("clock mode not taken from written byte");

  property p_clock_kept;
    @(posedge mclk) disable iff (!resetn)
      commit && !normal_op |=> $stable(clock_internal) && !converting && !tracking;
  endproperty
  a_clock_kept: assert property (p_clock_kept)
    else $error("power-down byte altered clock mode or kept converting");

  property p_ext_acq;
    @(posedge mclk) disable iff (!resetn)
      commit && normal_op && regs_ff.latch[POS_SAMPLE] |=> tracking ##1 tracking;
  endproperty
  a_ext_acq: assert property (p_ext_acq)
    else $error("external acquisition did not hold tracking");

  property p_abort;
    @(posedge mclk) disable iff (!resetn)
      commit && converting && normal_op && !regs_ff.latch[POS_SAMPLE]
      |=> tracking && done_flag_n;
  endproperty
  a_abort: assert property (p_abort)
    else $error("write during conversion did not restart acquisition");

  property p_conv_bound;
    @(posedge mclk) disable iff (!resetn)
      converting |-> regs_ff.cnt <= conv_last;
  endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion ran past its cycle count");

  property p_done_cause;
    @(posedge mclk) disable iff (!resetn)
      $fell(done_flag_n) |-> $past(converting) && !converting;
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done flag fell without a finishing conversion");

  property p_float;
    @(posedge mclk) disable iff (!resetn)
      chip_select_n |=> data_oe_n;
  endproperty
  a_float: assert property (p_float)
    else $error("bus driven while deselected");

  property p_low_byte;
    @(posedge mclk) disable iff (!resetn)
      !chip_select_n && !fetch_strobe_n && !upper_byte_select
      |=> !data_oe_n && data_out == $past(regs_ff.result[LOW_BYTE_W-1:0]);
  endproperty
  a_low_byte: assert property (p_low_byte)
    else $error("low byte read returned wrong bits");

  property p_high_byte;
    @(posedge mclk) disable iff (!resetn)
      upper_byte_select |=> data_out[CTRL_W-1] ==
        (!$past(polarity_sel) && $past(regs_ff.result[RES_W-1]));
  endproperty
  a_high_byte: assert property (p_high_byte)
    else $error("upper lines not zero or sign copies");

  property p_coding;
    @(posedge mclk) disable iff (!resetn)
      finish |=> regs_ff.result[RES_W-1] ==
        ($past(sample_code[RES_W-1]) ^ !$past(polarity_sel));
  endproperty
  a_coding: assert property (p_coding)
    else $error("result coding does not follow range select");

endmodule : acp_port

// ===== dv/acp_host.sv
// Host processor model on the shared byte bus
`timescale 1ns/1ps
module acp_host (
  input  wire logic       mclk,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe_n,
  output logic            chip_select_n,
  output logic            store_strobe_n,
  output logic            fetch_strobe_n,
  output logic            upper_byte_select,
  output logic            conv_clk,
  output logic [7:0]      data_in
);
  logic [7:0] drv_ff;
  logic       drv_on;
  logic       clk_on;
  logic       keep_cs;
  int         rises;
  // ****
  // Bus wire
  // ****
  // No pull on the bus: released lines show the inverse, not a stale byte
  assign data_in = !data_oe_n ? data_out : drv_on ? drv_ff : ~data_out;
  initial begin
    {chip_select_n, store_strobe_n, fetch_strobe_n} = 3'h7;
    {upper_byte_select, conv_clk, drv_on, clk_on, keep_cs} = 5'h0;
    drv_ff = 8'h00;
    rises = 0;
  end
  // Held low while clk_on is clear; 2.5 MHz, half duty
  always #200 conv_clk = clk_on ? ~conv_clk : 1'b0;
  always @(posedge conv_clk) rises++;
  task automatic wr(input logic [7:0] b, input logic cs);
    chip_select_n = cs;
    store_strobe_n = 1'b0;
    drv_ff = b;
    drv_on = 1'b1;
    @(posedge mclk) #1;
    store_strobe_n = 1'b1;
    @(posedge mclk) #1;
    drv_on = 1'b0;
    chip_select_n = !keep_cs;
  endtask : wr
  task automatic rd(input logic hi, input logic cs, output logic [7:0] q);
    chip_select_n = cs;
    fetch_strobe_n = 1'b0;
    upper_byte_select = hi;
    @(posedge mclk) #1;
    q = data_in;
    fetch_strobe_n = 1'b1;
    chip_select_n = !keep_cs;
    repeat (2) @(posedge mclk);
    #1;
  endtask : rd
endmodule : acp_host

// ===== dv/tb_top.sv
// Self-checking bench for the control byte port
`timescale 1ns/1ps
module tb_top;
  import acp_pkg::*;
  logic       mclk, resetn, chip_select_n, store_strobe_n, fetch_strobe_n;
  logic       upper_byte_select, conv_clk, data_oe_n, done_flag_n, clock_internal;
  logic       sample_window_sel, input_ref_sel, polarity_sel, tracking, converting;
  logic [7:0] data_in, data_out, q;
  logic [9:0] sample_code;
  logic [1:0] power_mode;
  logic [2:0] chan_sel;
  int         n_errors, n_compared, cyc, n;
  acp_port #(.CONV_CYCLES(CONV_CYC), .ACQ_CYCLES(ACQ_CYC)) dut_u (.mclk, .resetn,
    .chip_select_n, .store_strobe_n, .fetch_strobe_n, .upper_byte_select, .conv_clk,
    .data_in, .sample_code, .data_out, .data_oe_n, .done_flag_n, .power_mode,
    .clock_internal, .sample_window_sel, .input_ref_sel, .polarity_sel, .chan_sel,
    .tracking, .converting);
  acp_host host_u (.mclk, .data_out, .data_oe_n, .chip_select_n, .store_strobe_n,
    .fetch_strobe_n, .upper_byte_select, .conv_clk, .data_in);
  // ****
  // Common
  // ****
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  // Do-while: an old low flag is cleared on the commit edge itself, before wr returns
  task automatic wait_done(output int k);
    k = 0;
    do begin
      @(posedge mclk) #1;
      k++;
    end while (done_flag_n !== 1'b0 && k < 2000);
  endtask : wait_done
  // ****
  // Scenarios
  // ****
  task automatic t_ext();
    host_u.keep_cs = 1'b1;
    host_u.wr(8'hD3, 1'b0);
    host_u.rises = 0;
    host_u.clk_on = 1'b1;
    @(posedge mclk) #1;
    chk({power_mode, clock_internal, sample_window_sel, input_ref_sel, polarity_sel,
      chan_sel}, 9'h193);
    wait_done(n);
    chk(10'(host_u.rises), 10'(ACQ_EDGES + CONV_EDGES));
    host_u.clk_on = 1'b0;
    host_u.wr(8'h55, 1'b1);
    @(posedge mclk) #1;
    chk({done_flag_n, chan_sel}, 4'h3);
    host_u.rd(1'b1, 1'b1, q);
    chk({q, done_flag_n, data_oe_n}, 10'h001);
    chk(data_oe_n, 1'b1);
    host_u.rd(1'b0, 1'b0, q);
    chk(q, 8'hA5);
    chk({done_flag_n, data_oe_n}, 2'h3);
    host_u.rd(1'b1, 1'b0, q);
    chk(q, 8'hFF);
  endtask : t_ext
  task automatic t_int();
    host_u.clk_on = 1'b1;
    host_u.wr(8'h9D, 1'b0);
    repeat (60) @(posedge mclk);
    #1 host_u.wr(8'h9D, 1'b0);
    wait_done(n);
    chk(10'(n), 10'(ACQ_CYC + CONV_CYC));
    chk({power_mode, clock_internal, polarity_sel, chan_sel}, 7'h5D);
    host_u.rd(1'b0, 1'b0, q);
    chk(q, 8'hA5);
    chk(done_flag_n, 1'b1);
    host_u.rd(1'b1, 1'b0, q);
    chk(q, 8'h01);
    host_u.clk_on = 1'b0;
  endtask : t_int
  task automatic t_acq();
    host_u.wr(8'hBD, 1'b0);
    repeat (300) @(posedge mclk);
    #1 chk({done_flag_n, tracking, sample_window_sel}, 3'h7);
    host_u.wr(8'h9D, 1'b0);
    wait_done(n);
    chk(10'(n), 10'(CONV_CYC));
  endtask : t_acq
  task automatic t_pwr();
    host_u.wr(8'h00, 1'b0);
    @(posedge mclk) #1;
    chk({done_flag_n, power_mode, clock_internal, converting}, 5'h12);
    host_u.wr(8'h40, 1'b0);
    @(posedge mclk) #1;
    chk({power_mode, clock_internal}, 3'h3);
  endtask : t_pwr
  initial begin
    {mclk, resetn, n_errors, n_compared, cyc} = '0;
    sample_code = 10'h1A5;
    repeat (6) @(posedge mclk);
    #1 resetn = 1'b1;
    chk({clock_internal, power_mode, done_flag_n, data_oe_n}, 5'h03);
    t_ext();
    t_int();
    t_acq();
    t_pwr();
    end_sim();
  end
endmodule : tb_top
